// file: verilog/imr_pkg.sv
// constants and types shared by the interrupt and register front end
package imr_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_RAW_STATUS   = 8'h00;
    localparam logic [7:0] OFS_EVENT_MASK   = 8'h04;
    localparam logic [7:0] OFS_EVENT_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_CONFIG_ONE   = 8'h0C;
    localparam logic [7:0] OFS_CONFIG_TWO   = 8'h10;
    localparam logic [7:0] OFS_CONFIG_THREE = 8'h14;
    localparam logic [7:0] OFS_OWN_ADDRESS  = 8'h18;
    localparam logic [7:0] OFS_PAYLOAD      = 8'h1C;
    localparam logic [7:0] OFS_POINTER      = 8'h20;
    localparam logic [7:0] OFS_COMMAND      = 8'h24;

    // ****************************************************************
    // event field layout and reset values
    // ****************************************************************
    localparam int         EVENT_COUNT   = 4;
    localparam int         EV_ACK        = 0;
    localparam int         EV_STOP       = 1;
    localparam int         EV_NO_ACK     = 2;
    localparam int         EV_ARB_LOST   = 3;
    localparam int         ARB_ENA_BIT   = 28;
    localparam logic [3:0] RAW_RESET     = 4'h0;
    localparam logic [3:0] MASK_RESET    = 4'hF;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

    // ****************************************************************
    // decoded register selector
    // ****************************************************************
    typedef enum logic [3:0] {
        SEL_RAW    = 4'h0,
        SEL_MASK   = 4'h1,
        SEL_CLEAR  = 4'h2,
        SEL_CFG1   = 4'h3,
        SEL_CFG2   = 4'h4,
        SEL_CFG3   = 4'h5,
        SEL_OWN    = 4'h6,
        SEL_DATA   = 4'h7,
        SEL_PTR    = 4'h8,
        SEL_CMD    = 4'h9,
        SEL_NONE   = 4'hF
    } imr_sel_e;

    // ****************************************************************
    // complete module state
    // ****************************************************************
    typedef struct packed {
        logic        scl_meta;
        logic        scl_sync;
        logic        scl_prev;
        logic        sda_meta;
        logic        sda_sync;
        logic        sda_prev;
        logic [3:0]  raw;
        logic [3:0]  mask;
        logic [31:0] cfg_one;
        logic [31:0] cfg_two;
        logic [31:0] cfg_three;
        logic [31:0] own_addr;
        logic [31:0] payload;
        logic [31:0] pointer;
        logic [31:0] command;
        logic        command_strobe;
        logic [31:0] rdata;
        logic        err;
    } imr_state_s;

endpackage

// file: verilog/imr_regs.sv
// interrupt status, mask, clear and register map of the serial bus master
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module imr_regs
    import imr_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    input  wire logic                  tx_bit_active,
    input  wire logic                  tx_bit_one,
    input  wire logic                  ack_slot,
    input  wire logic                  stop_pending,
    output logic                       irq,
    output logic [31:0]                config_one,
    output logic [31:0]                config_two,
    output logic [31:0]                config_three,
    output logic [31:0]                own_bus_address,
    output logic [31:0]                target_payload,
    output logic [31:0]                target_register_pointer,
    output logic [31:0]                command_value,
    output logic                       command_strobe
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("imr_regs: ADDR_WIDTH must lie between 8 and 32");
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic imr_sel_e decode(input logic [ADDR_WIDTH-1:0] a);
        logic [31:0] wide;
        imr_sel_e    sel;
        wide = 32'(a);
        sel  = SEL_NONE;
        if (wide[31:8] == 24'h00_0000) begin
            unique case (wide[7:0])
                OFS_RAW_STATUS:   sel = SEL_RAW;
                OFS_EVENT_MASK:   sel = SEL_MASK;
                OFS_EVENT_CLEAR:  sel = SEL_CLEAR;
                OFS_CONFIG_ONE:   sel = SEL_CFG1;
                OFS_CONFIG_TWO:   sel = SEL_CFG2;
                OFS_CONFIG_THREE: sel = SEL_CFG3;
                OFS_OWN_ADDRESS:  sel = SEL_OWN;
                OFS_PAYLOAD:      sel = SEL_DATA;
                OFS_POINTER:      sel = SEL_PTR;
                OFS_COMMAND:      sel = SEL_CMD;
                default:          sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    imr_state_s st;
    imr_state_s next_st;

    imr_sel_e   sel;
    logic       setup_phase;
    logic       write_take;
    logic       scl_rise;
    logic       stop_seen;
    logic [3:0] events;
    logic [3:0] clear_bits;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        sel         = decode(paddr);
        setup_phase = psel & ~penable;
        write_take  = psel & penable & pwrite;

        // serial bus pins pass two flops before anything reads them
        next_st.scl_meta = scl_in;
        next_st.scl_sync = st.scl_meta;
        next_st.scl_prev = st.scl_sync;
        next_st.sda_meta = sda_in;
        next_st.sda_sync = st.sda_meta;
        next_st.sda_prev = st.sda_sync;

        scl_rise  = st.scl_sync & ~st.scl_prev;
        // data rising while clock stays high marks a finished stop
        stop_seen = st.sda_sync & ~st.sda_prev & st.scl_sync & st.scl_prev;

        events = 4'h0;
        events[EV_ARB_LOST] = scl_rise & tx_bit_active & tx_bit_one & ~st.sda_sync
                              & st.cfg_one[ARB_ENA_BIT];
        events[EV_NO_ACK]   = scl_rise & ack_slot & st.sda_sync;
        events[EV_STOP]     = stop_seen & stop_pending;
        events[EV_ACK]      = scl_rise & ack_slot & ~st.sda_sync;

        clear_bits = 4'h0;
        if (write_take && sel == SEL_CLEAR) begin
            clear_bits = pwdata[3:0];
        end
        // an event in the clearing cycle wins over the clear
        next_st.raw = (st.raw & ~clear_bits) | events;

        next_st.command_strobe = 1'b0;
        if (write_take) begin
            unique case (sel)
                SEL_MASK: next_st.mask = pwdata[3:0];
                SEL_CFG1: next_st.cfg_one = pwdata;
                SEL_CFG2: next_st.cfg_two = pwdata;
                SEL_CFG3: next_st.cfg_three = pwdata;
                SEL_OWN:  next_st.own_addr = pwdata;
                SEL_DATA: next_st.payload = pwdata;
                SEL_PTR:  next_st.pointer = pwdata;
                SEL_CMD: begin
                    next_st.command        = pwdata;
                    next_st.command_strobe = 1'b1;
                end
                default: next_st.err = st.err;
            endcase
        end

        // read data and error are captured in the setup cycle
        if (setup_phase) begin
            next_st.err   = (sel == SEL_NONE);
            next_st.rdata = WORD_RESET;
            if (!pwrite) begin
                unique case (sel)
                    SEL_RAW:  next_st.rdata = {28'h000_0000, st.raw};
                    SEL_MASK: next_st.rdata = {28'h000_0000, st.mask};
                    SEL_CFG1: next_st.rdata = st.cfg_one;
                    SEL_CFG2: next_st.rdata = st.cfg_two;
                    SEL_CFG3: next_st.rdata = st.cfg_three;
                    SEL_OWN:  next_st.rdata = st.own_addr;
                    SEL_DATA: next_st.rdata = st.payload;
                    SEL_PTR:  next_st.rdata = st.pointer;
                    default:  next_st.rdata = WORD_RESET;
                endcase
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                <= '0;
            st.raw            <= RAW_RESET;
            st.mask           <= MASK_RESET;
            st.cfg_one        <= WORD_RESET;
            st.cfg_two        <= WORD_RESET;
            st.cfg_three      <= WORD_RESET;
            st.own_addr       <= WORD_RESET;
            st.payload        <= WORD_RESET;
            st.pointer        <= WORD_RESET;
            st.command        <= WORD_RESET;
            st.rdata          <= WORD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pready                  = 1'b1;
    assign prdata                  = st.rdata;
    assign pslverr                 = st.err & psel & penable;
    assign irq                     = |(st.raw & ~st.mask);
    assign config_one              = st.cfg_one;
    assign config_two              = st.cfg_two;
    assign config_three            = st.cfg_three;
    assign own_bus_address         = st.own_addr;
    assign target_payload          = st.payload;
    assign target_register_pointer = st.pointer;
    assign command_value           = st.command;
    assign command_strobe          = st.command_strobe;

endmodule

// file: test/imr_checker.sv
// port assertions for the interrupt and register front end
`timescale 1ns/1ps
module imr_checker #(parameter int ADDR_WIDTH = 12) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic                  irq,
    input wire logic                  command_strobe
);
    wire acc = psel && penable;
    wire rd  = acc && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_UNMAP: assert property (acc && paddr > 12'h024 |-> pslverr) else $error("no error on unmapped");
    AST_MAP: assert property (acc && paddr <= 12'h024 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped");
    AST_CLR_RD: assert property (rd && paddr == 12'h008 |-> prdata == 32'h0) else $error("clear not zero");
    AST_RSVD: assert property (rd && paddr <= 12'h004 |-> prdata[31:4] == 28'h0) else $error("reserved set");
    AST_IDLE: assert property (rd && paddr == 12'h000 && prdata[3:0] == 4'h0 |-> !$past(irq)) else $error("irq");
    AST_STICKY: assert property ($fell(irq) |-> $past(acc && pwrite && (paddr == 12'h004 || paddr == 12'h008)))
        else $error("irq fell without write");
    AST_CMD: assert property (acc && pwrite && paddr == 12'h024 |=> command_strobe ##1 !command_strobe)
        else $error("bad command pulse");
    AST_CMD_SRC: assert property ($rose(command_strobe) |-> $past(acc && pwrite && paddr == 12'h024))
        else $error("stray command pulse");
endmodule

bind imr_regs imr_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_imr_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .command_strobe(command_strobe));

// file: test/imr_bus_model.sv
// far side of the serial bus: one bit or one stop condition per request
`timescale 1ns/1ps
module imr_bus_model (
    input wire logic start_bit,
    input wire logic bit_val,
    input wire logic start_stop,
    output logic     scl,
    output logic     sda
);
    initial {scl, sda} = 2'b11;
    // clock moves only inside a request; data returns to the pull-up level after
    always @(posedge start_bit) begin
        scl = 1'b0;
        #100 sda = start_stop ? 1'b0 : bit_val;
        #100 scl = 1'b1;
        #100 sda = 1'b1;
    end
endmodule

// file: test/tb_top.sv
// register bus and serial event bench for the interrupt front end
`timescale 1ns/1ps
module tb_top
    import imr_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, irq, scl_in, sda_in, start_bit, bit_val;
    logic        tx_bit_active, tx_bit_one, ack_slot, stop_pending, start_stop, err_seen;
    logic [31:0] cfg_one_seen, cmd_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          fails, samples_checked, cycles;

    imr_regs i_imr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl_in(scl_in),
        .sda_in(sda_in), .tx_bit_active(tx_bit_active), .tx_bit_one(tx_bit_one), .ack_slot(ack_slot),
        .stop_pending(stop_pending), .irq(irq), .config_one(cfg_one_seen), .config_two(), .config_three(),
        .own_bus_address(), .target_payload(), .target_register_pointer(), .command_value(cmd_seen),
        .command_strobe());
    imr_bus_model i_imr_bus_model (.start_bit(start_bit), .bit_val(bit_val), .start_stop(start_stop),
        .scl(scl_in), .sda(sda_in));

    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) if (++cycles == 5000) test_done(1'b1);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) $display("[FAIL] %s expected %h seen %h", n, e, g);
        fails += int'(g !== e);
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 4'h0, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err_seen = pslverr;
        if (!w) chk($sformatf("read %h", a), e, prdata);
        {psel, penable} <= 2'b00;
        @(negedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e); xfer(1'b0, a, 32'h0, e); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d, 32'h0); endtask

    task automatic serial(input logic [3:0] q, input logic v);
        @(posedge pclk);
        {stop_pending, ack_slot, tx_bit_one, tx_bit_active} <= q;
        {bit_val, start_stop, start_bit} <= {v, q[3], 1'b1};
        repeat (12) @(posedge pclk);
        {stop_pending, ack_slot, tx_bit_one, tx_bit_active, start_stop, start_bit} <= 6'h00;
        repeat (4) @(posedge pclk);
    endtask

    task automatic test_done(input bit t);
        fails += t;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_bit_active, tx_bit_one, ack_slot, stop_pending, start_bit, bit_val, start_stop} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_RAW_STATUS, 32'h0);
        rd(OFS_EVENT_MASK, 32'hF);
        rd(OFS_EVENT_CLEAR, 32'h0);
        wr(OFS_EVENT_MASK, 32'hFFFF_FFFA);
        rd(OFS_EVENT_MASK, 32'hA);
        chk("pslverr mapped", 32'h0, 32'(err_seen));
        wr(OFS_COMMAND, 32'h1);
        chk("command_value", 32'h1, cmd_seen);
        rd(8'h28, 32'h0);
        chk("pslverr unmapped", 32'h1, 32'(err_seen));
        serial(4'h4, 1'b0);
        rd(OFS_RAW_STATUS, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        serial(4'h4, 1'b1);
        rd(OFS_RAW_STATUS, 32'h5);
        serial(4'h3, 1'b0);
        rd(OFS_RAW_STATUS, 32'h5);
        for (int i = 3; i < 9; i++) begin
            wr(8'(4 * i), 32'h1000_0000 | 32'(i));
            rd(8'(4 * i), 32'h1000_0000 | 32'(i));
        end
        chk("config_one", 32'h1000_0003, cfg_one_seen);
        serial(4'h3, 1'b0);
        rd(OFS_RAW_STATUS, 32'hD);
        serial(4'h8, 1'b0);
        rd(OFS_RAW_STATUS, 32'hF);
        $display("test map and events done");
        wr(OFS_EVENT_MASK, 32'hF);
        chk("irq", 32'h0, 32'(irq));
        wr(OFS_EVENT_CLEAR, 32'h0);
        rd(OFS_RAW_STATUS, 32'hF);
        wr(OFS_EVENT_CLEAR, 32'h5);
        rd(OFS_RAW_STATUS, 32'hA);
        wr(OFS_EVENT_MASK, 32'h7);
        chk("irq", 32'h1, 32'(irq));
        wr(OFS_EVENT_CLEAR, 32'hFFFF_FFFF);
        rd(OFS_RAW_STATUS, 32'h0);
        $display("test mask and clear done");
        test_done(1'b0);
    end
endmodule
